/* adc_cfg_map.svh */
// Offsets, field positions, masks and reset values of the configuration bank
`ifndef ADC_CFG_MAP_SVH
`define ADC_CFG_MAP_SVH
`define OFF_STATUS 8'h00
`define OFF_GENERAL 8'h01
`define OFF_OUTDATA 8'h02
`define OFF_AVERAGING 8'h03
`define OFF_OPMODE 8'h04
`define OFF_CHANFN 8'h05
`define BIT_REF_EN 7
`define BIT_CRC_EN 6
`define BIT_RANGE 3
`define BIT_FORCE 2
`define BIT_CAL 1
`define BIT_SWRST 0
`define BIT_PATTERN 7
`define LSB_APPEND 4
`define LSB_CLKMODE 0
`define LSB_RATIO 0
`define BIT_OSC 4
`define LSB_CLKDIV 0
`define BIT_BROWNOUT 0
`define BIT_CHKERR 1
`define BIT_STAT_FIXED 7
`define MASK_GENERAL 8'hce
`define MASK_OUTDATA 8'hb3
`define MASK_AVERAGING 8'h07
`define MASK_OPMODE 8'h1f
`define MASK_CHANFN 8'hff
`define RST_GENERAL 8'h00
`define RST_OUTDATA 8'h00
`define RST_AVERAGING 8'h00
`define RST_OPMODE 8'h01
`define RST_CHANFN 8'h00
`define RST_BROWNOUT 1'b1
`define APPEND_RESERVED 2'h3
`define APPEND_CHAN_ID 2'h1
`define APPEND_STATUS 2'h2
`define DEBUG_PATTERN 16'ha5a5
`endif

/* adc_cfg_pkg.sv */
// Types shared by the configuration bank and its users
package adc_cfg_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
    logic [3:0] chan_id;
    logic [3:0] status;
  } conv_in_t;

  typedef struct packed {
    logic [7:0] general;
    logic [7:0] outdata;
    logic [7:0] averaging;
    logic [7:0] opmode;
    logic [7:0] chanfn;
    logic [7:0] gpio_mask;
    logic brownout;
    logic chkerr;
    logic cal_start;
    logic [7:0] rdata;
    logic rvalid;
    logic [15:0] dword;
    logic [3:0] dtail;
    logic dvalid;
    logic tvalid;
  } bank_state_t;
endpackage : adc_cfg_pkg

/* adc_config_register_bank.sv */
// Configuration register bank of an eight-channel converter with GPIO-capable channels
`include "adc_cfg_map.svh"
`timescale 1ns/1ps
`default_nettype none
module adc_config_register_bank
  import adc_cfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire reg_req_t req,
  input wire conv_in_t conv,
  input wire logic cal_done,
  input wire logic brownout_event,
  input wire logic check_error_event,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic ref_enable,
  output logic crc_enable,
  output logic range_double,
  output logic force_all_analog,
  output logic cal_busy,
  output logic cal_start,
  output logic debug_pattern_enable,
  output logic [1:0] append_mode,
  output logic [1:0] serial_clock_mode,
  output logic [2:0] averaging_ratio,
  output logic oscillator_select,
  output logic [3:0] clock_divider,
  output logic [7:0] channel_gpio_mask,
  output logic brownout_flag,
  output logic incoming_check_error_flag,
  output logic [15:0] data_word,
  output logic [3:0] data_tail,
  output logic data_valid,
  output logic tail_valid
);
  bank_state_t state_reg;
  bank_state_t state_next;
  logic wr_ok;

  // Power-up and software reset share these defaults
  function automatic bank_state_t defaults();
    bank_state_t d;
    d = '0;
    d.general = `RST_GENERAL;
    d.outdata = `RST_OUTDATA;
    d.averaging = `RST_AVERAGING;
    d.opmode = `RST_OPMODE;
    d.chanfn = `RST_CHANFN;
    d.gpio_mask = `RST_CHANFN;
    d.brownout = `RST_BROWNOUT;
    return d;
  endfunction : defaults

  always_comb begin
    state_next = state_reg;
    state_next.rvalid = 1'b0;
    state_next.cal_start = 1'b0;
    state_next.dvalid = 1'b0;
    state_next.tvalid = 1'b0;
    // Status and general stay writable so software can recover from a check error
    wr_ok = req.wr && (!state_reg.chkerr || req.addr == `OFF_STATUS ||
                       req.addr == `OFF_GENERAL);
    // Completion clears first so a fresh start in the same cycle wins
    if (cal_done) begin
      state_next.general[`BIT_CAL] = 1'b0;
    end
    if (wr_ok) begin
      if (req.addr == `OFF_STATUS) begin
        if (req.wdata[`BIT_BROWNOUT]) begin
          state_next.brownout = 1'b0;
        end
        if (req.wdata[`BIT_CHKERR]) begin
          state_next.chkerr = 1'b0;
        end
      end else if (req.addr == `OFF_GENERAL) begin
        if (req.wdata[`BIT_SWRST]) begin
          state_next = defaults();
          state_next.brownout = 1'b1;
        end else begin
          state_next.general = req.wdata & `MASK_GENERAL;
          // A general write without the reset bit cannot abort a running calibration; a software reset clears it
          state_next.general[`BIT_CAL] = state_reg.general[`BIT_CAL] && !cal_done ||
                                         req.wdata[`BIT_CAL];
          state_next.cal_start = req.wdata[`BIT_CAL] &&
                                 (!state_reg.general[`BIT_CAL] || cal_done);
        end
      end else if (req.addr == `OFF_OUTDATA) begin
        state_next.outdata = req.wdata & `MASK_OUTDATA;
        // A reserved append code is refused and the old code kept
        if (req.wdata[`LSB_APPEND +: 2] == `APPEND_RESERVED) begin
          state_next.outdata[`LSB_APPEND +: 2] = state_reg.outdata[`LSB_APPEND +: 2];
        end
      end else if (req.addr == `OFF_AVERAGING) begin
        state_next.averaging = req.wdata & `MASK_AVERAGING;
      end else if (req.addr == `OFF_OPMODE) begin
        state_next.opmode = req.wdata & `MASK_OPMODE;
      end else if (req.addr == `OFF_CHANFN) begin
        state_next.chanfn = req.wdata & `MASK_CHANFN;
      end
    end
    // Events set after any clear, so a flag raised during its clear survives
    if (brownout_event) begin
      state_next.brownout = 1'b1;
    end
    if (check_error_event && state_reg.general[`BIT_CRC_EN]) begin
      state_next.chkerr = 1'b1;
    end
    if (req.rd) begin
      state_next.rvalid = 1'b1;
      if (req.addr == `OFF_STATUS) begin
        state_next.rdata = 8'h00;
        state_next.rdata[`BIT_STAT_FIXED] = 1'b1;
        state_next.rdata[`BIT_CHKERR] = state_reg.chkerr;
        state_next.rdata[`BIT_BROWNOUT] = state_reg.brownout;
      end else if (req.addr == `OFF_GENERAL) begin
        state_next.rdata = state_reg.general;
      end else if (req.addr == `OFF_OUTDATA) begin
        state_next.rdata = state_reg.outdata;
      end else if (req.addr == `OFF_AVERAGING) begin
        state_next.rdata = state_reg.averaging;
      end else if (req.addr == `OFF_OPMODE) begin
        state_next.rdata = state_reg.opmode;
      end else if (req.addr == `OFF_CHANFN) begin
        state_next.rdata = state_reg.chanfn;
      end else begin
        state_next.rdata = 8'h00;
      end
    end
    if (conv.valid) begin
      state_next.dvalid = 1'b1;
      state_next.dword = state_reg.outdata[`BIT_PATTERN] ? `DEBUG_PATTERN : conv.data;
      state_next.tvalid = state_reg.outdata[`LSB_APPEND +: 2] != 2'h0;
      if (state_reg.outdata[`LSB_APPEND +: 2] == `APPEND_CHAN_ID) begin
        state_next.dtail = conv.chan_id;
      end else if (state_reg.outdata[`LSB_APPEND +: 2] == `APPEND_STATUS) begin
        state_next.dtail = conv.status;
      end else begin
        state_next.dtail = 4'h0;
      end
    end
    // Force overrides the per-channel choice without disturbing the stored value
    state_next.gpio_mask = state_next.chanfn &
                           {8{!state_next.general[`BIT_FORCE]}};
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_reg <= defaults();
    end else begin
      state_reg <= state_next;
    end
  end

  assign rd_data = state_reg.rdata;
  assign rd_valid = state_reg.rvalid;
  assign ref_enable = state_reg.general[`BIT_REF_EN];
  assign crc_enable = state_reg.general[`BIT_CRC_EN];
  assign range_double = state_reg.general[`BIT_RANGE];
  assign force_all_analog = state_reg.general[`BIT_FORCE];
  assign cal_busy = state_reg.general[`BIT_CAL];
  assign cal_start = state_reg.cal_start;
  assign debug_pattern_enable = state_reg.outdata[`BIT_PATTERN];
  assign append_mode = state_reg.outdata[`LSB_APPEND +: 2];
  assign serial_clock_mode = state_reg.outdata[`LSB_CLKMODE +: 2];
  assign averaging_ratio = state_reg.averaging[`LSB_RATIO +: 3];
  assign oscillator_select = state_reg.opmode[`BIT_OSC];
  assign clock_divider = state_reg.opmode[`LSB_CLKDIV +: 4];
  assign channel_gpio_mask = state_reg.gpio_mask;
  assign brownout_flag = state_reg.brownout;
  assign incoming_check_error_flag = state_reg.chkerr;
  assign data_word = state_reg.dword;
  assign data_tail = state_reg.dtail;
  assign data_valid = state_reg.dvalid;
  assign tail_valid = state_reg.tvalid;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic gen_wr;
  assign gen_wr = wr_ok && req.addr == `OFF_GENERAL && !req.wdata[`BIT_SWRST];

  // Software reset write, kept apart so other properties can exclude it
  logic sw_rst_wr;
  assign sw_rst_wr = wr_ok && req.addr == `OFF_GENERAL && req.wdata[`BIT_SWRST];

  a_ref_enable_write: assert property (
    gen_wr |=> ref_enable == $past(req.wdata[`BIT_REF_EN]))
    else $error("reference enable did not follow write");

  a_crc_enable_write: assert property (
    gen_wr |=> crc_enable == $past(req.wdata[`BIT_CRC_EN]))
    else $error("crc enable did not follow write");

  a_range_select_write: assert property (
    gen_wr |=> range_double == $past(req.wdata[`BIT_RANGE]))
    else $error("range select did not follow write");

  a_force_all_analog: assert property (
    force_all_analog |-> channel_gpio_mask == 8'h00)
    else $error("gpio channel while forced analog");

  sequence cal_req_s;
    gen_wr && req.wdata[`BIT_CAL] && !cal_busy && !cal_done;
  endsequence
  sequence cal_run_s;
    cal_start && cal_busy ##1 !cal_start;
  endsequence
  a_cal_start_busy: assert property (cal_req_s |=> cal_run_s)
    else $error("calibration start not signalled");

  a_cal_done_clear: assert property (
    cal_done && !(gen_wr && req.wdata[`BIT_CAL]) |=> !cal_busy)
    else $error("calibration bit not cleared");

  a_soft_reset_defaults: assert property (
    wr_ok && req.addr == `OFF_GENERAL && req.wdata[`BIT_SWRST] |=>
      state_reg.general == `RST_GENERAL && state_reg.opmode == `RST_OPMODE &&
      state_reg.chanfn == `RST_CHANFN && brownout_flag)
    else $error("software reset left state");

  a_debug_pattern_data: assert property (
    conv.valid && debug_pattern_enable |=> data_valid && data_word == `DEBUG_PATTERN)
    else $error("debug pattern missing");

  a_append_reserved_kept: assert property (
    wr_ok && req.addr == `OFF_OUTDATA &&
      req.wdata[`LSB_APPEND +: 2] == `APPEND_RESERVED |=> $stable(append_mode))
    else $error("reserved append code accepted");

  a_clock_mode_write: assert property (
    wr_ok && req.addr == `OFF_OUTDATA |=>
      serial_clock_mode == $past(req.wdata[`LSB_CLKMODE +: 2]))
    else $error("clock mode did not follow write");

  a_ratio_write: assert property (
    wr_ok && req.addr == `OFF_AVERAGING |=> averaging_ratio == $past(req.wdata[2:0]))
    else $error("averaging ratio did not follow write");

  a_opmode_write: assert property (
    wr_ok && req.addr == `OFF_OPMODE |=>
      oscillator_select == $past(req.wdata[`BIT_OSC]) &&
      clock_divider == $past(req.wdata[3:0]))
    else $error("operating mode did not follow write");

  a_opmode_reset_read: assert property (
    $rose(nrst) |-> state_reg.opmode == `RST_OPMODE && state_reg.general == `RST_GENERAL)
    else $error("operating mode reset value wrong");

  a_channel_mask: assert property (
    !force_all_analog |-> channel_gpio_mask == state_reg.chanfn)
    else $error("channel function mismatch");

  a_blocked_write: assert property (
    incoming_check_error_flag && req.wr && req.addr == `OFF_CHANFN |=> $stable(state_reg.chanfn))
    else $error("write taken during check error");

  a_brownout_clear: assert property (
    wr_ok && req.addr == `OFF_STATUS && req.wdata[`BIT_BROWNOUT] && !brownout_event
      |=> !brownout_flag ##1 brownout_flag == $past(brownout_event || sw_rst_wr))
    else $error("brownout flag clear wrong");

  a_reserved_zero: assert property (
    rd_valid |-> (rd_data & ~`MASK_OPMODE) == 8'h00 || $past(req.addr) != `OFF_OPMODE)
    else $error("reserved bits read nonzero");

  a_status_read_fixed: assert property (
    req.rd && req.addr == `OFF_STATUS |=> rd_valid && rd_data[`BIT_STAT_FIXED] &&
      (rd_data & 8'h7c) == 8'h00 && rd_data[`BIT_BROWNOUT] == $past(brownout_flag))
    else $error("status read layout wrong");

  a_unmapped_read_zero: assert property (
    req.rd && req.addr > `OFF_CHANFN |=> rd_valid && rd_data == 8'h00)
    else $error("unmapped offset read nonzero");

  a_general_reserved_zero: assert property (
    req.rd && req.addr == `OFF_GENERAL |=> (rd_data & ~`MASK_GENERAL) == 8'h00)
    else $error("general reserved bits read nonzero");

  a_outdata_reserved_zero: assert property (
    req.rd && req.addr == `OFF_OUTDATA |=> (rd_data & ~`MASK_OUTDATA) == 8'h00)
    else $error("output data reserved bits read nonzero");

  a_check_error_set: assert property (
    check_error_event && crc_enable |=> incoming_check_error_flag)
    else $error("check error not latched");

  a_check_error_gated: assert property (
    check_error_event && !crc_enable && !incoming_check_error_flag && !sw_rst_wr |=>
      !incoming_check_error_flag)
    else $error("check error latched with crc off");

  a_brownout_event_set: assert property (
    brownout_event |=> brownout_flag)
    else $error("brownout event lost");

  a_data_passthrough: assert property (
    conv.valid && !debug_pattern_enable |=> data_valid && data_word == $past(conv.data))
    else $error("conversion data altered");

  sequence tail_id_s;
    conv.valid && append_mode == `APPEND_CHAN_ID;
  endsequence
  sequence tail_status_s;
    conv.valid && append_mode == `APPEND_STATUS;
  endsequence
  a_tail_channel_id: assert property (
    tail_id_s |=> tail_valid && data_tail == $past(conv.chan_id))
    else $error("channel id tail wrong");

  a_tail_status: assert property (
    tail_status_s |=> tail_valid && data_tail == $past(conv.status))
    else $error("status tail wrong");

  a_tail_none: assert property (
    conv.valid && append_mode == 2'h0 |=> data_valid && !tail_valid)
    else $error("tail sent with append off");

  a_cal_no_abort: assert property (
    cal_busy && !cal_done && !sw_rst_wr |=> cal_busy)
    else $error("calibration aborted early");

  a_soft_reset_opmode: assert property (
    sw_rst_wr |=> clock_divider == 4'h1 && !oscillator_select && averaging_ratio == 3'h0)
    else $error("software reset left operating mode");
endmodule : adc_config_register_bank
`default_nettype wire

/* adc_host_model.sv */
// Host side model of the register port and the calibration engine
`timescale 1ns/1ps
`default_nettype none
module adc_host_model
  import adc_cfg_pkg::*;
(
  input wire logic ref_clk,
  output var reg_req_t req,
  input wire logic cal_start,
  output var logic cal_done,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  int cal_wait = 4;

  initial begin
    req = '0;
    cal_done = 1'b0;
  end

  // Address and data are inverted once released so stale values never look valid
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    #1 req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    d = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask : read_reg

  // Conversion engine ends the calibration after a settable delay
  always begin
    @(posedge ref_clk);
    #2;
    if (cal_start === 1'b1) begin
      repeat (cal_wait) @(posedge ref_clk);
      #1 cal_done = 1'b1;
      @(posedge ref_clk);
      #1 cal_done = 1'b0;
    end
  end
endmodule : adc_host_model
`default_nettype wire

/* adc_config_register_bank_test.sv */
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module adc_config_register_bank_test
  import adc_cfg_pkg::*;
;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  reg_req_t req;
  conv_in_t conv = '0;
  logic cal_done, brownout_event = 1'b0, check_error_event = 1'b0;
  logic [7:0] rd_data, channel_gpio_mask;
  logic rd_valid, ref_enable, crc_enable, range_double, force_all_analog, cal_busy, cal_start;
  logic debug_pattern_enable, oscillator_select, brownout_flag, incoming_check_error_flag;
  logic [1:0] append_mode, serial_clock_mode;
  logic [2:0] averaging_ratio;
  logic [3:0] clock_divider, data_tail;
  logic [15:0] data_word;
  logic data_valid, tail_valid;
  int bad_count = 0;
  int tests_run = 0;
  int i;
  localparam logic [7:0] rst_exp [7] = '{8'h81, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  localparam int waits [2] = '{4, 30};

  always #10 ref_clk = ~ref_clk;

  adc_host_model host (.ref_clk, .req, .cal_start, .cal_done, .rd_data, .rd_valid);

  adc_config_register_bank dut (.ref_clk, .nrst, .req, .conv, .cal_done, .brownout_event,
    .check_error_event, .rd_data, .rd_valid, .ref_enable, .crc_enable, .range_double,
    .force_all_analog, .cal_busy, .cal_start, .debug_pattern_enable, .append_mode,
    .serial_clock_mode, .averaging_ratio, .oscillator_select, .clock_divider,
    .channel_gpio_mask, .brownout_flag, .incoming_check_error_flag, .data_word, .data_tail,
    .data_valid, .tail_valid);

  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    host.read_reg(a, v);
    `CHK("register read", e, v)
  endtask : rchk

  // One-cycle event pulse: brown-out when k is set, otherwise a failed check
  task automatic ev(input bit k);
    @(posedge ref_clk);
    #1 if (k) brownout_event = 1'b1; else check_error_event = 1'b1;
    @(posedge ref_clk);
    #1 brownout_event = 1'b0;
    check_error_event = 1'b0;
  endtask : ev

  task automatic cv(input logic [15:0] d, input logic [3:0] id, input logic [3:0] st);
    @(posedge ref_clk);
    #1 conv = '{valid: 1'b1, data: d, chan_id: id, status: st};
    @(posedge ref_clk);
    #1 conv = '{valid: 1'b0, data: ~d, chan_id: ~id, status: ~st};
    `CHK("data_valid", 1'b1, data_valid)
  endtask : cv

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    summarize();
  end

  initial begin
    repeat (2) @(posedge ref_clk);
    #1 nrst = 1'b1;
    for (i = 0; i < 7; i++) rchk(i[7:0], rst_exp[i]);
    host.write_reg(8'h01, 8'hfc);
    `CHK("ref_enable", 1'b1, ref_enable)
    `CHK("crc_enable", 1'b1, crc_enable)
    `CHK("range_double", 1'b1, range_double)
    `CHK("force_all_analog", 1'b1, force_all_analog)
    rchk(8'h01, 8'hcc);
    host.write_reg(8'h05, 8'ha5);
    `CHK("channel_gpio_mask", 8'h00, channel_gpio_mask)
    host.write_reg(8'h01, 8'h48);
    `CHK("ref_enable", 1'b0, ref_enable)
    `CHK("channel_gpio_mask", 8'ha5, channel_gpio_mask)
    // Failed check blocks every write but the status and general ones
    ev(1'b0);
    `CHK("incoming_check_error_flag", 1'b1, incoming_check_error_flag)
    host.write_reg(8'h05, 8'h3c);
    host.write_reg(8'h01, 8'hc8);
    `CHK("ref_enable", 1'b1, ref_enable)
    rchk(8'h05, 8'ha5);
    host.write_reg(8'h00, 8'h02);
    `CHK("incoming_check_error_flag", 1'b0, incoming_check_error_flag)
    host.write_reg(8'h05, 8'h3c);
    rchk(8'h05, 8'h3c);
    host.write_reg(8'h00, 8'h01);
    `CHK("brownout_flag", 1'b0, brownout_flag)
    ev(1'b1);
    rchk(8'h00, 8'h81);
    foreach (waits[j]) begin
      host.cal_wait = waits[j];
      host.write_reg(8'h01, 8'h02);
      `CHK("cal_busy", 1'b1, cal_busy)
      `CHK("cal_start", 1'b1, cal_start)
      rchk(8'h01, 8'h02);
      for (i = 0; i < 100 && cal_busy !== 1'b0; i++) #20;
      if (i == 100) begin
        bad_count++;
        summarize();
      end
      rchk(8'h01, 8'h00);
    end
    ev(1'b0);
    `CHK("incoming_check_error_flag", 1'b0, incoming_check_error_flag)
    host.write_reg(8'h02, 8'h91);
    `CHK("debug_pattern_enable", 1'b1, debug_pattern_enable)
    cv(16'h1234, 4'h6, 4'h9);
    `CHK("data_word", 16'ha5a5, data_word)
    `CHK("data_tail", 4'h6, data_tail)
    `CHK("tail_valid", 1'b1, tail_valid)
    host.write_reg(8'h02, 8'h2e);
    rchk(8'h02, 8'h22);
    host.write_reg(8'h02, 8'h30);
    `CHK("append_mode", 2'h2, append_mode)
    `CHK("debug_pattern_enable", 1'b0, debug_pattern_enable)
    cv(16'h1234, 4'h6, 4'h9);
    `CHK("data_word", 16'h1234, data_word)
    `CHK("data_tail", 4'h9, data_tail)
    host.write_reg(8'h02, 8'h00);
    cv(16'h4321, 4'h6, 4'h9);
    `CHK("tail_valid", 1'b0, tail_valid)
    for (i = 0; i < 4; i++) begin
      host.write_reg(8'h02, i[7:0]);
      `CHK("serial_clock_mode", i[1:0], serial_clock_mode)
    end
    for (i = 0; i < 8; i++) begin
      host.write_reg(8'h03, {5'h1f, i[2:0]});
      `CHK("averaging_ratio", i[2:0], averaging_ratio)
    end
    rchk(8'h03, 8'h07);
    host.write_reg(8'h04, 8'hfa);
    `CHK("oscillator_select", 1'b1, oscillator_select)
    `CHK("clock_divider", 4'ha, clock_divider)
    rchk(8'h04, 8'h1a);
    // Unmapped write, then software reset restores every default
    host.write_reg(8'h00, 8'h01);
    host.write_reg(8'h06, 8'hff);
    host.write_reg(8'h01, 8'h01);
    `CHK("brownout_flag", 1'b1, brownout_flag)
    for (i = 0; i < 7; i++) rchk(i[7:0], rst_exp[i]);
    summarize();
  end
endmodule : adc_config_register_bank_test
`default_nettype wire
